// ==== verilog/trm_pkg.sv ====
package trm_pkg;

  // timer population and field geometry
  localparam int unsigned NUM_TIMERS = 8;
  localparam int unsigned RST_TIMERS = 6;
  localparam int unsigned PAIR_SPAN  = 4;
  localparam int unsigned SRC_LINES  = 8;

  // model-specific register addresses
  localparam logic [31:0] ADDR_IRQ_MASK   = 32'h51400028;
  localparam logic [31:0] ADDR_NR_MASK    = 32'h51400029;
  localparam logic [31:0] ADDR_RSVD       = 32'h5140002a;
  localparam logic [31:0] ADDR_TEST_SETUP = 32'h5140002b;

  // reset values
  localparam logic [31:0] IRQ_MASK_RESET = 32'h00000000;
  localparam logic [31:0] NR_MASK_RESET  = 32'h00000000;
  localparam logic [31:0] READ_ZERO      = 32'h00000000;

  // writable bits; everything else is reserved and reads zero
  localparam logic [31:0] IRQ_MASK_RW = 32'h0000ffff;
  localparam logic [31:0] NR_MASK_RW  = 32'h3f01ffff;

  // field positions
  localparam int unsigned IRQ_C1_LSB  = 0;
  localparam int unsigned IRQ_C2_LSB  = 8;
  localparam int unsigned NR_C1_LSB   = 0;
  localparam int unsigned NR_C2_LSB   = 8;
  localparam int unsigned NR_LEG_BIT  = 16;
  localparam int unsigned NR_RST_LSB  = 24;

  // one register-path request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] addr;
    logic [31:0] wdata;
  } trm_msr_req_t;

  // comparator outputs of all timers
  typedef struct packed {
    logic [NUM_TIMERS-1:0] cmp1;
    logic [NUM_TIMERS-1:0] cmp2;
  } trm_cmp_t;

endpackage : trm_pkg

// ==== verilog/trm_msr_decode.sv ====
`timescale 1ns/10ps
module trm_msr_decode (
  input  wire trm_pkg::trm_msr_req_t req,          // register-path request
  input  wire logic [31:0]           irq_mask,     // current route mask
  input  wire logic [31:0]           nr_mask,      // current nmi/reset mask
  output wire logic                  irq_wr,       // write hits route mask
  output wire logic                  nr_wr,        // write hits nmi/reset mask
  output wire logic [31:0]           rdata         // read data for this address
);

  ////////////////////////////////////////////////////////////////////////////
  // address match
  wire logic hit_irq;
  wire logic hit_nr;

  assign hit_irq = (req.addr == trm_pkg::ADDR_IRQ_MASK);
  assign hit_nr  = (req.addr == trm_pkg::ADDR_NR_MASK);

  // reserved, test-setup and unmapped addresses read zero, writes dropped
  assign irq_wr = req.wr & hit_irq;
  assign nr_wr  = req.wr & hit_nr;

  // read select; reserved bits already held at zero in storage
  assign rdata = hit_irq ? (irq_mask & trm_pkg::IRQ_MASK_RW) :
                 hit_nr  ? (nr_mask & trm_pkg::NR_MASK_RW)   :
                           trm_pkg::READ_ZERO;

endmodule : trm_msr_decode

// ==== verilog/trm_route.sv ====
`timescale 1ns/10ps
module trm_route #(
  parameter int unsigned NT = trm_pkg::NUM_TIMERS  // timers feeding the router
) (
  input  wire trm_pkg::trm_cmp_t cmp,           // comparator outputs
  input  wire logic [31:0]       irq_mask,      // route mask register
  input  wire logic [31:0]       nr_mask,       // nmi/reset mask register
  input  wire logic              rtc_nmi_mask,  // legacy nmi mask, high blocks
  output wire logic [7:0]        irq_src,       // shared interrupt source lines
  output wire logic              nmi,           // combined nmi request
  output wire logic              hard_rst       // combined hard reset request
);

  ////////////////////////////////////////////////////////////////////////////
  // enabled comparator terms
  wire logic [NT-1:0] c1_irq;
  wire logic [NT-1:0] c2_irq;
  wire logic [NT-1:0] c1_nmi;
  wire logic [NT-1:0] c2_nmi;
  wire logic [trm_pkg::RST_TIMERS-1:0] c2_rst;
  wire logic          nmi_any;
  wire logic          leg_block;

  assign c1_irq = cmp.cmp1 & irq_mask[trm_pkg::IRQ_C1_LSB +: NT];
  assign c2_irq = cmp.cmp2 & irq_mask[trm_pkg::IRQ_C2_LSB +: NT];

  assign c1_nmi = cmp.cmp1 & nr_mask[trm_pkg::NR_C1_LSB +: NT];
  assign c2_nmi = cmp.cmp2 & nr_mask[trm_pkg::NR_C2_LSB +: NT];
  assign c2_rst = cmp.cmp2[trm_pkg::RST_TIMERS-1:0] & nr_mask[trm_pkg::NR_RST_LSB +: trm_pkg::RST_TIMERS];

  // pair n with n+4 onto one line
  genvar g;
  generate
    for (g = 0; g < trm_pkg::PAIR_SPAN; g++)
    begin : g_pair
      assign irq_src[g] = c1_irq[g] | c1_irq[g+trm_pkg::PAIR_SPAN];
      assign irq_src[g+trm_pkg::PAIR_SPAN] = c2_irq[g] | c2_irq[g+trm_pkg::PAIR_SPAN];
    end
  endgenerate

  assign nmi_any   = |{c1_nmi, c2_nmi};
  // legacy mask only counts when gating enabled
  assign leg_block = nr_mask[trm_pkg::NR_LEG_BIT] & rtc_nmi_mask;
  assign nmi       = nmi_any & ~leg_block;
  assign hard_rst  = |c2_rst;

endmodule : trm_route

// ==== verilog/trm_top.sv ====
// How it works
// - line 0 ORs enabled cmp1 of timers 0,4
// - line 1 ORs enabled cmp1 of timers 1,5
// - line 2 ORs enabled cmp1 of timers 2,6
// - line 3 ORs enabled cmp1 of timers 3,7
// - cleared route bit blocks that comparator
// - bits 24-29 let cmp2 cause reset
// - bits 8-15 let cmp2 raise nmi
// - bit 16 adds legacy rtc nmi mask
// - reserved mask bits ignore writes, read zero
// - nmi/reset mask rw, clears at reset
// - bits 0-7 let cmp1 raise nmi
// - lines 4-7 OR enabled cmp2 pairs
`timescale 1ns/10ps
module trm_top (
  input  wire logic                  clk,             // 100 MHz system clock
  input  wire logic                  sys_rst,         // synchronous reset, high
  input  wire trm_pkg::trm_msr_req_t msr_req,         // register-path request
  input  wire trm_pkg::trm_cmp_t     cmp,             // timer comparator outputs
  input  wire logic                  rtc_nmi_mask,    // rtc index bit 7, high blocks
  output logic [31:0]                msr_rdata,       // read data, registered
  output logic                       msr_ack,         // access done pulse
  output logic [7:0]                 irq_src,         // shared source lines to mapper
  output logic                       nmi_req,         // nmi to processor path
  output logic                       hard_reset_req   // hard reset to reset logic
);

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [31:0] timer_irq_route_mask_reg;
  logic [31:0] timer_irq_route_mask_next;
  logic [31:0] timer_nmi_reset_mask_reg;
  logic [31:0] timer_nmi_reset_mask_next;

  wire logic        irq_wr;
  wire logic        nr_wr;
  wire logic [31:0] rd_sel;
  wire logic [7:0]  irq_src_c;
  wire logic        nmi_c;
  wire logic        rst_c;

  // merge write data into writable bits only
  function automatic logic [31:0] masked_write(input logic [31:0] wdata, input logic [31:0] rw);
    masked_write = wdata & rw;
  endfunction : masked_write

  ////////////////////////////////////////////////////////////////////////////
  // address decode and read select
  trm_msr_decode u_decode (
    .req      (msr_req),
    .irq_mask (timer_irq_route_mask_reg),
    .nr_mask  (timer_nmi_reset_mask_reg),
    .irq_wr   (irq_wr),
    .nr_wr    (nr_wr),
    .rdata    (rd_sel)
  );

  assign timer_irq_route_mask_next = irq_wr ? masked_write(msr_req.wdata, trm_pkg::IRQ_MASK_RW)
                                            : timer_irq_route_mask_reg;
  assign timer_nmi_reset_mask_next = nr_wr ? masked_write(msr_req.wdata, trm_pkg::NR_MASK_RW)
                                           : timer_nmi_reset_mask_reg;

  // both masks clear so nothing fires until enabled
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      timer_irq_route_mask_reg <= trm_pkg::IRQ_MASK_RESET;
      timer_nmi_reset_mask_reg <= trm_pkg::NR_MASK_RESET;
    end
    else
    begin
      timer_irq_route_mask_reg <= timer_irq_route_mask_next;
      timer_nmi_reset_mask_reg <= timer_nmi_reset_mask_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register-path answer: one cycle after any read or write
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      msr_rdata <= trm_pkg::READ_ZERO;
      msr_ack   <= 1'b0;
    end
    else
    begin
      msr_rdata <= msr_req.rd ? rd_sel : trm_pkg::READ_ZERO;
      msr_ack   <= msr_req.rd | msr_req.wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // routing of comparator outputs
  trm_route #(
    .NT (trm_pkg::NUM_TIMERS)
  ) u_route (
    .cmp          (cmp),
    .irq_mask     (timer_irq_route_mask_reg),
    .nr_mask      (timer_nmi_reset_mask_reg),
    .rtc_nmi_mask (rtc_nmi_mask),
    .irq_src      (irq_src_c),
    .nmi          (nmi_c),
    .hard_rst     (rst_c)
  );

  // outputs registered: one cycle latency, glitch-free toward the mapper
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irq_src        <= 8'h00;
      nmi_req        <= 1'b0;
      hard_reset_req <= 1'b0;
    end
    else
    begin
      irq_src        <= irq_src_c;
      nmi_req        <= nmi_c;
      hard_reset_req <= rst_c;
    end
  end

endmodule : trm_top

// ==== dv/trm_top_properties.sv ====
`timescale 1ns/10ps
module trm_top_checker (
  input wire logic                  clk,           // clock
  input wire logic                  sys_rst,       // sync reset
  input wire trm_pkg::trm_msr_req_t msr_req,       // request
  input wire trm_pkg::trm_cmp_t     cmp,           // comparators
  input wire logic                  rtc_nmi_mask,  // legacy mask
  input wire logic [31:0]           msr_rdata,     // read data
  input wire logic                  msr_ack,       // ack pulse
  input wire logic [7:0]            irq_src,       // source lines
  input wire logic                  nmi_req,       // nmi
  input wire logic                  hard_reset_req // hard reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // any access, read or write
  wire req = msr_req.rd | msr_req.wr;
  wire nr_rd = msr_req.rd && msr_req.addr == trm_pkg::ADDR_NR_MASK;
  wire rs_rd = msr_req.rd && msr_req.addr == trm_pkg::ADDR_RSVD;
  //////////////////////////////////////////////////////////////////////////////
  ack_pulse_a: assert property (req |=> msr_ack) else $error("no ack");
  ack_cause_a: assert property (msr_ack |-> $past(req)) else $error("stray ack");
  rdata_idle_a: assert property (!msr_ack |-> msr_rdata == 32'h0) else $error("rdata not idle");
  nr_rsvd_a: assert property (nr_rd |=> (msr_rdata & ~trm_pkg::NR_MASK_RW) == 32'h0) else $error("rsvd bit");
  rsvd_zero_a: assert property (rs_rd |=> msr_rdata == 32'h0) else $error("rsvd reg read");
  reset_clear_a: assert property ($fell(sys_rst) |-> {irq_src, nmi_req, hard_reset_req} == 10'h0)
    else $error("not clear");
  // low lines only follow cmp1 of the pair
  low_route_a: assert property ((irq_src[3:0] & ~$past(cmp.cmp1[3:0] | cmp.cmp1[7:4])) == 4'h0)
    else $error("low line");
  high_route_a: assert property ((irq_src[7:4] & ~$past(cmp.cmp2[3:0] | cmp.cmp2[7:4])) == 4'h0)
    else $error("high line");
  rst_src_a: assert property (hard_reset_req |-> $past(cmp.cmp2[5:0]) != 6'h0) else $error("reset src");
  nmi_src_a: assert property (nmi_req |-> $past(cmp) != 16'h0) else $error("nmi src");
  cover property (nmi_req);
  cover property (hard_reset_req);
  cover property (msr_ack && msr_rdata != 32'h0);
endmodule : trm_top_checker

// ==== dv/trm_far_model.sv ====
`timescale 1ns/10ps
module trm_far_model (
  input  wire logic       clk,     // clock
  input  wire logic       sys_rst, // sync reset
  input  wire logic [7:0] irq_src, // source lines
  output logic [7:0]      src_seen // lines seen high
);
  // mapper side keeps every line it saw, so no short pulse is lost
  always_ff @(posedge clk)
    if (sys_rst)
      src_seen <= 8'h00;
    else
      src_seen <= src_seen | irq_src;
endmodule : trm_far_model

// ==== dv/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  logic                  clk, sys_rst, rtc_nmi_mask, msr_ack, nmi_req, hard_reset_req;
  trm_pkg::trm_msr_req_t msr_req;
  trm_pkg::trm_cmp_t     cmp;
  logic [31:0]           msr_rdata;
  logic [7:0]            irq_src, src_seen;
  int                    bad_count, n_checks;
  trm_top uut (.clk(clk), .sys_rst(sys_rst), .msr_req(msr_req), .cmp(cmp), .rtc_nmi_mask(rtc_nmi_mask),
    .msr_rdata(msr_rdata), .msr_ack(msr_ack), .irq_src(irq_src), .nmi_req(nmi_req), .hard_reset_req(hard_reset_req));
  trm_far_model far (.clk(clk), .sys_rst(sys_rst), .irq_src(irq_src), .src_seen(src_seen));
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // one-cycle request pulse, answer looked at in its single cycle
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
    @(negedge clk);
    msr_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge clk);
    msr_req = '0;
    chk(msr_ack, 1);
    chk(msr_rdata, e);
  endtask : acc
  // comparators land one edge before outputs are judged
  task automatic route(input logic [15:0] c, input logic [9:0] e);
    @(negedge clk);
    cmp = c;
    @(negedge clk);
    chk({irq_src, nmi_req, hard_reset_req}, e);
  endtask : route
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {sys_rst, rtc_nmi_mask, cmp, msr_req, bad_count, n_checks} = '0;
    sys_rst = 1;
    repeat (2) @(negedge clk);
    sys_rst = 0;
    acc(0, trm_pkg::ADDR_IRQ_MASK, 0, trm_pkg::IRQ_MASK_RESET);
    acc(0, trm_pkg::ADDR_NR_MASK, 0, trm_pkg::NR_MASK_RESET);
    acc(1, trm_pkg::ADDR_NR_MASK, 32'hffffffff, 0);
    acc(0, trm_pkg::ADDR_NR_MASK, 0, trm_pkg::NR_MASK_RW);
    acc(1, trm_pkg::ADDR_IRQ_MASK, 32'hffffffff, 0);
    acc(0, trm_pkg::ADDR_IRQ_MASK, 0, trm_pkg::IRQ_MASK_RW);
    acc(1, trm_pkg::ADDR_RSVD, 32'hffffffff, 0);
    acc(0, trm_pkg::ADDR_RSVD, 0, 0);
    acc(0, 32'h00000010, 0, 0);
    $display("test registers done");
    // each timer alone on both comparators, every route and nmi enabled
    for (int t = 0; t < 8; t++)
    begin
      route({8'h01 << t, 8'h00}, {8'h01 << (t % 4), 1'b1, 1'b0});
      route({8'h00, 8'h01 << t}, {8'h10 << (t % 4), 1'b1, t < 6});
    end
    chk(src_seen, 32'h000000ff);
    $display("test routing done");
    acc(1, trm_pkg::ADDR_NR_MASK, 32'h00010001, 0);
    rtc_nmi_mask = 1;
    route({8'h01, 8'h00}, {8'h01, 1'b0, 1'b0});
    rtc_nmi_mask = 0;
    route({8'h01, 8'h00}, {8'h01, 1'b1, 1'b0});
    acc(1, trm_pkg::ADDR_NR_MASK, 32'h00000001, 0);
    rtc_nmi_mask = 1;
    route({8'h00, 8'h00}, {8'h00, 1'b0, 1'b0});
    route({8'h01, 8'h00}, {8'h01, 1'b1, 1'b0});
    $display("test legacy gate done");
    acc(1, trm_pkg::ADDR_IRQ_MASK, 32'h0000ffef, 0);
    acc(1, trm_pkg::ADDR_NR_MASK, 32'h00000100, 0);
    route({8'h10, 8'h02}, {8'h20, 1'b0, 1'b0});
    acc(1, trm_pkg::ADDR_IRQ_MASK, 0, 0);
    route({8'hff, 8'hfe}, {8'h00, 1'b0, 1'b0});
    $display("test masking done");
    close_out();
  end
  // bound generously above the 74 cycles the tests need
  initial
  begin
    #20000;
    bad_count++;
    close_out();
  end
endmodule : testbench
bind trm_top trm_top_checker chk_i (.clk(clk), .sys_rst(sys_rst), .msr_req(msr_req), .cmp(cmp),
  .rtc_nmi_mask(rtc_nmi_mask), .msr_rdata(msr_rdata), .msr_ack(msr_ack), .irq_src(irq_src),
  .nmi_req(nmi_req), .hard_reset_req(hard_reset_req));
